// File: pkg/scr_pkg.sv
// Constants and types shared by the switch configuration register bank
package scr_pkg;
  localparam int unsigned CLK_MHZ = 10;
  // Register addresses on the two-wire bus
  localparam logic [7:0] ADDR_HS = 8'h00;
  localparam logic [7:0] ADDR_AUX = 8'h01;
  localparam logic [7:0] ADDR_RX = 8'h10;
  localparam logic [7:0] ADDR_PULSE = 8'h11;
  // Reset values
  localparam logic [7:0] RST_HS = 8'h40;
  localparam logic [7:0] RST_AUX = 8'h40;
  localparam logic [7:0] RST_RX = 8'h01;
  localparam logic [7:0] RST_PULSE = 8'h00;
  localparam logic [7:0] RST_STRAP = 8'h00;
  // Mode register fields
  localparam int unsigned EN_BIT = 6;
  localparam int unsigned SM_LO = 4;
  localparam int unsigned CH_LO = 0;
  localparam logic [1:0] SM_QUAD = 2'h0;
  localparam logic [1:0] SM_ILLEGAL = 2'h3;
  localparam logic [7:0] RX_MASK = 8'h01;
  localparam logic [7:0] MODE_MASK = 8'h7f;
  // Fixed upper bits of the slave address
  localparam logic [3:0] SLAVE_ADDR_FIXED = 4'h9;
  // Positions within the synchronised pin vector
  localparam int unsigned PIN_SCL = 0;
  localparam int unsigned PIN_SDA = 1;
  localparam int unsigned PIN_ADDR_LO = 2;
  localparam int unsigned PIN_STRAP_LO = 5;
  localparam int unsigned PIN_W = 13;
  localparam logic [12:0] PIN_RST = 13'h0003;
  // Positions within the parallel strap byte
  localparam int unsigned STRAP_EN = 0;
  localparam int unsigned STRAP_CH_LO = 1;
  localparam int unsigned STRAP_EQ = 3;
  localparam int unsigned STRAP_PRE_LO = 4;
  localparam int unsigned STRAP_OTO = 6;
  localparam int unsigned STRAP_OCL = 7;
  // Update delay windows; least times, rounded up to whole cycles
  localparam int unsigned UPD_NS_HS = 20000;
  localparam int unsigned UPD_NS_AUX = 10000;
  localparam int unsigned UPD_NS_RX = 10000;
  localparam int unsigned UPD_NS_PULSE = 10000;
  localparam int unsigned UPD_NS_STRAP = 10000;
  localparam int unsigned UPD_CYC_HS = (UPD_NS_HS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UPD_CYC_AUX = (UPD_NS_AUX * CLK_MHZ + 999) / 1000;
  localparam int unsigned UPD_CYC_RX = (UPD_NS_RX * CLK_MHZ + 999) / 1000;
  localparam int unsigned UPD_CYC_PULSE = (UPD_NS_PULSE * CLK_MHZ + 999) / 1000;
  localparam int unsigned UPD_CYC_STRAP = (UPD_NS_STRAP * CLK_MHZ + 999) / 1000;
  localparam int unsigned NUM_WIN = 5;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_REG = 9'h008,
    ST_REG_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RDATA_ACK = 9'h100
  } scr_state_e;
endpackage

// File: pkg/scr_pin_if.sv
// Filtered pin levels and their edges, passed from the synchroniser to the bank
`timescale 1ns/1ps
interface scr_pin_if #(parameter int Width = 13);
  logic [Width-1:0] level;
  logic [Width-1:0] rise;
  logic [Width-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// File: design/scr_pin_sync.sv
// Three-flop synchroniser with agreement filter and edge pulses for external pins
`timescale 1ns/1ps
module scr_pin_sync #(
  parameter int Width = 13,
  parameter logic [Width-1:0] RstVal = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [Width-1:0] pinIn,
  scr_pin_if.src pins
);
  if (Width < 1)
  begin : g_chk
    $error("scr_pin_sync: Width must be at least one");
  end
  for (genvar i = 0; i < Width; i++)
  begin : g_bit
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;
    logic rise_ff;
    logic fall_ff;
    // Only the second stage reads the first; the filter looks at stages two and three
    always_ff @(posedge clk)
    begin
      if (!rstn)
      begin
        s1_ff <= RstVal[i];
        s2_ff <= RstVal[i];
        s3_ff <= RstVal[i];
      end
      else
      begin
        s1_ff <= pinIn[i];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
      end
    end
    always_ff @(posedge clk)
    begin
      if (!rstn)
      begin
        lvl_ff <= RstVal[i];
        rise_ff <= 1'b0;
        fall_ff <= 1'b0;
      end
      else
      begin
        if (s2_ff == s3_ff)
        begin
          lvl_ff <= s3_ff;
        end
        rise_ff <= (s2_ff == s3_ff) && s3_ff && !lvl_ff;
        fall_ff <= (s2_ff == s3_ff) && !s3_ff && lvl_ff;
      end
    end
    assign pins.level[i] = lvl_ff;
    assign pins.rise[i] = rise_ff;
    assign pins.fall[i] = fall_ff;
  end
endmodule // scr_pin_sync

// File: design/scr_config_regs.sv
// Configuration register bank with two-wire slave, parallel straps and update delay
//
// Summary of operation
// - Slave address is 1001 plus three strap bits, sent MSB first.
// - Write bit, then register address byte; both phases are acknowledged.
// - After read address acknowledge, selected register byte goes out MSB first.
// - After repeated start accept write, new read, or read of retained address.
// - Serial write starts the update delay at SCL fall of last data bit.
// - Parallel pin change starts the same register specific update delay.
// - Writes inside a window do not restart it; latest value applies at end.
// - Write after a window closes applies at once and opens a new window.
// - Straps control after reset; first own slave address match takes over until reset.
// - While straps control, their levels update the parallel configuration register.
// - Register 0x00: enable bit 6, mode bits 5:4, source bits 3:0, reset 0x40.
// - Register 0x01: same layout for side path, reset 0x40.
// - Register 0x10: input termination select in bit 0, reset 0x01.
// - Register 0x11: eight termination pulse bits for sources A and B, reset 0x00.
// - All mapped registers are readable and writable over the serial bus.
// - Enable zero puts fast path in standby; one turns it on.
// - Mode 00 quad, 01 dual, 10 single; writing 11 keeps the old mode.
// - Write sends one data byte MSB first; device stores and acknowledges it.
`timescale 1ns/1ps
module scr_config_regs #(
  parameter int unsigned UpdCyc [scr_pkg::NUM_WIN] = '{scr_pkg::UPD_CYC_HS, scr_pkg::UPD_CYC_AUX,
    scr_pkg::UPD_CYC_RX, scr_pkg::UPD_CYC_PULSE, scr_pkg::UPD_CYC_STRAP}
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic slaveAddrStrap2,
  input wire logic slaveAddrStrap1,
  input wire logic slaveAddrStrap0,
  input wire logic strapEnable,
  input wire logic [1:0] strapChannelSel,
  input wire logic strapEqualizer,
  input wire logic [1:0] strapPreemphasis,
  input wire logic strapOutTermination,
  input wire logic strapOutCurrent,
  output logic fastPathEnable,
  output logic [1:0] fastPathSwitchMode,
  output logic [3:0] fastPathSourceSel,
  output logic sidePathEnable,
  output logic [1:0] sidePathSwitchMode,
  output logic [3:0] sidePathSourceSel,
  output logic inputTermSel,
  output logic [7:0] termPulseSel,
  output logic equalizerBoost,
  output logic [1:0] preemphasisLevel,
  output logic outTermEnable,
  output logic outCurrentLevel,
  output logic serialCtrlActive
);
  scr_pin_if #(.Width(scr_pkg::PIN_W)) pins ();

  scr_pin_sync #(
    .Width(scr_pkg::PIN_W),
    .RstVal(scr_pkg::PIN_RST)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .pinIn({strapOutCurrent, strapOutTermination, strapPreemphasis, strapEqualizer, strapChannelSel,
      strapEnable, slaveAddrStrap2, slaveAddrStrap1, slaveAddrStrap0, sdaIn, sclIn}),
    .pins(pins)
  );

  scr_pkg::scr_state_e state_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic rdWr_ff;
  logic [7:0] regAddr_ff;
  logic sdaOe_ff;
  logic serMode_ff;
  logic [7:0] hs_ff;
  logic [7:0] aux_ff;
  logic [7:0] rx_ff;
  logic [7:0] pulse_ff;
  logic [7:0] strap_ff;
  logic [7:0] nxt_hs;
  logic [7:0] nxt_aux;
  logic [7:0] nxt_rx;
  logic [7:0] nxt_pulse;
  logic [7:0] nxt_strap;
  logic [7:0] rdData;
  logic [7:0] eff [scr_pkg::NUM_WIN];
  logic [7:0] appl [scr_pkg::NUM_WIN];
  logic [scr_pkg::NUM_WIN-1:0] winEv;
  logic sclRise;
  logic sclFall;
  logic sdaLvl;
  logic busStart;
  logic busStop;
  logic byteDone;
  logic addrHit;
  logic evAddrOk;
  logic evRegDone;
  logic evWrDone;
  logic takeover;
  logic serNow;
  logic [7:0] strapChg;

  assign sclRise = pins.rise[scr_pkg::PIN_SCL];
  assign sclFall = pins.fall[scr_pkg::PIN_SCL];
  assign sdaLvl = pins.level[scr_pkg::PIN_SDA];
  assign busStart = pins.fall[scr_pkg::PIN_SDA] && pins.level[scr_pkg::PIN_SCL];
  assign busStop = pins.rise[scr_pkg::PIN_SDA] && pins.level[scr_pkg::PIN_SCL];
  assign byteDone = sclFall && (bitCnt_ff == 4'h8);
  assign addrHit = shift_ff[7:1] == {scr_pkg::SLAVE_ADDR_FIXED,
    pins.level[scr_pkg::PIN_ADDR_LO+2], pins.level[scr_pkg::PIN_ADDR_LO+1],
    pins.level[scr_pkg::PIN_ADDR_LO]};
  assign evAddrOk = (state_ff == scr_pkg::ST_ADDR) && byteDone && addrHit;
  assign evRegDone = (state_ff == scr_pkg::ST_REG) && byteDone;
  assign evWrDone = (state_ff == scr_pkg::ST_WDATA) && byteDone;
  assign takeover = evAddrOk && !serMode_ff;
  assign serNow = serMode_ff || takeover;
  assign strapChg = (pins.rise[scr_pkg::PIN_STRAP_LO +: 8] | pins.fall[scr_pkg::PIN_STRAP_LO +: 8])
    & {8{!serMode_ff}};

  // Bus protocol sequencer
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_ff <= scr_pkg::ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
    end
    else if (busStart)
    begin
      state_ff <= scr_pkg::ST_ADDR;
      bitCnt_ff <= 4'h0;
    end
    else if (busStop)
    begin
      state_ff <= scr_pkg::ST_IDLE;
      bitCnt_ff <= 4'h0;
    end
    else
    begin
      unique case (state_ff)
        scr_pkg::ST_IDLE:
        begin
          bitCnt_ff <= 4'h0;
        end
        scr_pkg::ST_ADDR, scr_pkg::ST_REG, scr_pkg::ST_WDATA:
        begin
          if (sclRise && bitCnt_ff != 4'h8)
          begin
            shift_ff <= {shift_ff[6:0], sdaLvl};
            bitCnt_ff <= bitCnt_ff + 4'h1;
          end
          else if (byteDone)
          begin
            bitCnt_ff <= 4'h0;
            if (state_ff == scr_pkg::ST_ADDR)
            begin
              state_ff <= addrHit ? scr_pkg::ST_ADDR_ACK : scr_pkg::ST_IDLE;
            end
            else if (state_ff == scr_pkg::ST_REG)
            begin
              state_ff <= scr_pkg::ST_REG_ACK;
            end
            else
            begin
              state_ff <= scr_pkg::ST_WDATA_ACK;
            end
          end
        end
        scr_pkg::ST_ADDR_ACK:
        begin
          if (sclFall && rdWr_ff)
          begin
            shift_ff <= rdData;
            state_ff <= scr_pkg::ST_RDATA;
          end
          else if (sclFall)
          begin
            state_ff <= scr_pkg::ST_REG;
          end
        end
        scr_pkg::ST_REG_ACK:
        begin
          if (sclFall)
          begin
            state_ff <= scr_pkg::ST_WDATA;
          end
        end
        scr_pkg::ST_WDATA_ACK:
        begin
          // Only one data byte per write; further bytes are not acknowledged
          if (sclFall)
          begin
            state_ff <= scr_pkg::ST_IDLE;
          end
        end
        scr_pkg::ST_RDATA:
        begin
          if (sclRise)
          begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
          end
          else if (byteDone)
          begin
            bitCnt_ff <= 4'h0;
            state_ff <= scr_pkg::ST_RDATA_ACK;
          end
          else if (sclFall)
          begin
            shift_ff <= {shift_ff[6:0], 1'b0};
          end
        end
        scr_pkg::ST_RDATA_ACK:
        begin
          // Master acknowledge is not needed to end the byte; wait for stop or repeated start
          if (sclFall)
          begin
            state_ff <= scr_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_ff <= scr_pkg::ST_IDLE;
          bitCnt_ff <= 4'h0;
        end
      endcase
    end
  end

  // Direction bit and retained register address
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdWr_ff <= 1'b0;
      regAddr_ff <= 8'h00;
    end
    else
    begin
      if (evAddrOk)
      begin
        rdWr_ff <= shift_ff[0];
      end
      if (evRegDone)
      begin
        regAddr_ff <= shift_ff;
      end
    end
  end

  // Open-drain data line: only ever pulled low
  always_ff @(posedge clk)
  begin
    if (!rstn || busStart || busStop)
    begin
      sdaOe_ff <= 1'b0;
    end
    else if (evAddrOk || evRegDone || evWrDone)
    begin
      sdaOe_ff <= 1'b1;
    end
    else if (sclFall && state_ff == scr_pkg::ST_ADDR_ACK && rdWr_ff)
    begin
      sdaOe_ff <= !rdData[7];
    end
    else if (sclFall && state_ff == scr_pkg::ST_RDATA && bitCnt_ff != 4'h8)
    begin
      sdaOe_ff <= !shift_ff[6];
    end
    else if (sclFall)
    begin
      sdaOe_ff <= 1'b0;
    end
  end
  assign sdaOe = sdaOe_ff;
  assign sdaOut = 1'b0;

  // Register read mux; unmapped addresses read as zero
  always_comb
  begin
    unique case (regAddr_ff)
      scr_pkg::ADDR_HS: rdData = hs_ff;
      scr_pkg::ADDR_AUX: rdData = aux_ff;
      scr_pkg::ADDR_RX: rdData = rx_ff;
      scr_pkg::ADDR_PULSE: rdData = pulse_ff;
      default: rdData = 8'h00;
    endcase
  end

  // Next register values; a mode write of 11 keeps the previous mode
  always_comb
  begin
    nxt_hs = hs_ff;
    nxt_aux = aux_ff;
    nxt_rx = rx_ff;
    nxt_pulse = pulse_ff;
    if (evWrDone && regAddr_ff == scr_pkg::ADDR_HS)
    begin
      nxt_hs = shift_ff & scr_pkg::MODE_MASK;
      if (shift_ff[scr_pkg::SM_LO +: 2] == scr_pkg::SM_ILLEGAL)
      begin
        nxt_hs[scr_pkg::SM_LO +: 2] = hs_ff[scr_pkg::SM_LO +: 2];
      end
    end
    if (evWrDone && regAddr_ff == scr_pkg::ADDR_AUX)
    begin
      nxt_aux = shift_ff & scr_pkg::MODE_MASK;
      if (shift_ff[scr_pkg::SM_LO +: 2] == scr_pkg::SM_ILLEGAL)
      begin
        nxt_aux[scr_pkg::SM_LO +: 2] = aux_ff[scr_pkg::SM_LO +: 2];
      end
    end
    if (evWrDone && regAddr_ff == scr_pkg::ADDR_RX)
    begin
      nxt_rx = shift_ff & scr_pkg::RX_MASK;
    end
    if (evWrDone && regAddr_ff == scr_pkg::ADDR_PULSE)
    begin
      nxt_pulse = shift_ff;
    end
  end

  // Straps are tracked only until the serial bus takes over
  assign nxt_strap = serMode_ff ? strap_ff : pins.level[scr_pkg::PIN_STRAP_LO +: 8];

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      hs_ff <= scr_pkg::RST_HS;
      aux_ff <= scr_pkg::RST_AUX;
      rx_ff <= scr_pkg::RST_RX;
      pulse_ff <= scr_pkg::RST_PULSE;
      strap_ff <= scr_pkg::RST_STRAP;
    end
    else
    begin
      hs_ff <= nxt_hs;
      aux_ff <= nxt_aux;
      rx_ff <= nxt_rx;
      pulse_ff <= nxt_pulse;
      strap_ff <= nxt_strap;
    end
  end

  // Serial ownership is sticky until reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      serMode_ff <= 1'b0;
    end
    else if (takeover)
    begin
      serMode_ff <= 1'b1;
    end
  end
  assign serialCtrlActive = serMode_ff;

  // Effective settings: straps or fixed defaults in parallel mode, register-held in serial mode
  always_comb
  begin
    eff[0] = serNow ? nxt_hs : {1'b0, nxt_strap[scr_pkg::STRAP_EN], scr_pkg::SM_QUAD,
      2'b00, nxt_strap[scr_pkg::STRAP_CH_LO +: 2]};
    eff[1] = serNow ? nxt_aux : {1'b0, 1'b1, scr_pkg::SM_QUAD, 2'b00, nxt_strap[scr_pkg::STRAP_CH_LO +: 2]};
    eff[2] = serNow ? nxt_rx : scr_pkg::RST_RX;
    eff[3] = serNow ? nxt_pulse : scr_pkg::RST_PULSE;
    eff[4] = nxt_strap;
  end

  always_comb
  begin
    winEv[0] = takeover || (evWrDone && regAddr_ff == scr_pkg::ADDR_HS) ||
      strapChg[scr_pkg::STRAP_EN] || (|strapChg[scr_pkg::STRAP_CH_LO +: 2]);
    winEv[1] = takeover || (evWrDone && regAddr_ff == scr_pkg::ADDR_AUX) ||
      (|strapChg[scr_pkg::STRAP_CH_LO +: 2]);
    winEv[2] = takeover || (evWrDone && regAddr_ff == scr_pkg::ADDR_RX);
    winEv[3] = takeover || (evWrDone && regAddr_ff == scr_pkg::ADDR_PULSE);
    winEv[4] = strapChg[scr_pkg::STRAP_EQ] || (|strapChg[scr_pkg::STRAP_PRE_LO +: 2]) ||
      strapChg[scr_pkg::STRAP_OTO] || strapChg[scr_pkg::STRAP_OCL];
  end

  // One update delay window per setting group
  for (genvar i = 0; i < scr_pkg::NUM_WIN; i++)
  begin : g_win
    localparam logic [7:0] RstAppl = (i == 0) ? scr_pkg::RST_HS : (i == 1) ? scr_pkg::RST_AUX :
      (i == 2) ? scr_pkg::RST_RX : (i == 3) ? scr_pkg::RST_PULSE : scr_pkg::RST_STRAP;
    logic [15:0] cnt_ff;
    logic [7:0] appl_ff;
    if (UpdCyc[i] < 1 || UpdCyc[i] > 65535)
    begin : g_chk
      $error("scr_config_regs: update delay count out of range");
    end
    always_ff @(posedge clk)
    begin
      if (!rstn)
      begin
        cnt_ff <= 16'h0000;
        appl_ff <= RstAppl;
      end
      else if (cnt_ff == 16'h0000)
      begin
        if (winEv[i])
        begin
          appl_ff <= eff[i];
          cnt_ff <= 16'(UpdCyc[i]);
        end
      end
      else
      begin
        // Events inside the window are absorbed; the latest value lands at its end
        cnt_ff <= cnt_ff - 16'h0001;
        if (cnt_ff == 16'h0001)
        begin
          appl_ff <= eff[i];
        end
      end
    end
    assign appl[i] = appl_ff;
  end

  assign fastPathEnable = appl[0][scr_pkg::EN_BIT];
  assign fastPathSwitchMode = appl[0][scr_pkg::SM_LO +: 2];
  assign fastPathSourceSel = appl[0][scr_pkg::CH_LO +: 4];
  assign sidePathEnable = appl[1][scr_pkg::EN_BIT];
  assign sidePathSwitchMode = appl[1][scr_pkg::SM_LO +: 2];
  assign sidePathSourceSel = appl[1][scr_pkg::CH_LO +: 4];
  assign inputTermSel = appl[2][0];
  assign termPulseSel = appl[3];
  assign equalizerBoost = appl[4][scr_pkg::STRAP_EQ];
  assign preemphasisLevel = appl[4][scr_pkg::STRAP_PRE_LO +: 2];
  assign outTermEnable = appl[4][scr_pkg::STRAP_OTO];
  assign outCurrentLevel = appl[4][scr_pkg::STRAP_OCL];
endmodule // scr_config_regs

// File: verification/scr_config_regs_sva.sv
// Port-level assertions for the switch configuration register bank
`timescale 1ns/1ps
module scr_config_regs_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic fastPathEnable,
  input wire logic [1:0] fastPathSwitchMode,
  input wire logic sidePathEnable,
  input wire logic [1:0] sidePathSwitchMode,
  input wire logic inputTermSel,
  input wire logic [7:0] termPulseSel,
  input wire logic equalizerBoost,
  input wire logic [1:0] preemphasisLevel,
  input wire logic outTermEnable,
  input wire logic outCurrentLevel,
  input wire logic serialCtrlActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [4:0] extras;
  assign extras = {equalizerBoost, preemphasisLevel, outTermEnable, outCurrentLevel};
  property p_reset_vals;
    disable iff (1'b0)
    !rstn |=> !sdaOe && !serialCtrlActive && fastPathEnable && inputTermSel && termPulseSel == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_sticky;
    serialCtrlActive |=> serialCtrlActive;
  endproperty
  a_sticky: assert property (p_sticky) else $error("serial control dropped");
  property p_takeover_ack;
    $rose(serialCtrlActive) |-> $rose(sdaOe);
  endproperty
  a_takeover_ack: assert property (p_takeover_ack) else $error("takeover without ack");
  // Data may only move while the bus clock is low
  property p_low_phase;
    $changed(sdaOe) |-> !$past(sclIn);
  endproperty
  a_low_phase: assert property (p_low_phase) else $error("drive change in high phase");
  property p_hold;
    $rose(sdaOe) |=> sdaOe [*6];
  endproperty
  a_hold: assert property (p_hold) else $error("low drive too short");
  property p_mode;
    fastPathSwitchMode != scr_pkg::SM_ILLEGAL && sidePathSwitchMode != scr_pkg::SM_ILLEGAL;
  endproperty
  a_mode: assert property (p_mode) else $error("illegal mode applied");
  property p_frozen;
    serialCtrlActive && $past(serialCtrlActive) |-> $stable(extras);
  endproperty
  a_frozen: assert property (p_frozen) else $error("strap extras moved");
  property p_parallel;
    !serialCtrlActive |-> sidePathEnable && sidePathSwitchMode == 2'h0 && fastPathSwitchMode == 2'h0
      && inputTermSel && termPulseSel == 8'h00;
  endproperty
  a_parallel: assert property (p_parallel) else $error("parallel values wrong");
  property p_quiet;
    !serialCtrlActive |-> !sdaOe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus driven before own address");
  property p_open_drain;
    sdaOut == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  cover property ($rose(serialCtrlActive));
  cover property ($fell(inputTermSel));
  cover property ($changed(termPulseSel));
  cover property (fastPathSwitchMode == 2'h2);
endmodule // scr_config_regs_sva
bind scr_config_regs scr_config_regs_sva chk (.clk, .rstn, .sclIn, .sdaOut, .sdaOe, .fastPathEnable,
  .fastPathSwitchMode, .sidePathEnable, .sidePathSwitchMode, .inputTermSel, .termPulseSel,
  .equalizerBoost, .preemphasisLevel, .outTermEnable, .outCurrentLevel, .serialCtrlActive);

// File: verification/scr_bus_master.sv
// Behavioural two-wire bus master facing the register bank
`timescale 1ns/1ps
module scr_bus_master (
  input wire logic clk,
  input wire logic sdaIn,
  output logic scl,
  output logic mOe
);
  // Clock stands high between frames; low 6, high 2 lets the slave's answer settle before the rise
  initial
  begin
    scl = 1'b1;
    mOe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    w(2);
    if (!scl)
    begin
      mOe = 1'b0;
      w(4);
      scl = 1'b1;
      w(4);
    end
    mOe = 1'b1;
    w(4);
    scl = 1'b0;
  endtask
  task automatic bitx(input logic b, output logic r);
    w(2);
    mOe = !b;
    w(4);
    scl = 1'b1;
    w(1);
    r = sdaIn;
    w(1);
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(m, a);
  endtask
  task automatic stop();
    w(2);
    mOe = 1'b1;
    w(3);
    scl = 1'b1;
    w(4);
    mOe = 1'b0;
    w(4);
  endtask
  task automatic wr(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] d, output logic [2:0] nak);
    logic [7:0] q;
    start();
    xfer({sa, 1'b0}, 1'b1, q, nak[2]);
    xfer(ra, 1'b1, q, nak[1]);
    xfer(d, 1'b1, q, nak[0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] sa, input logic [7:0] ra, input logic useReg, output logic [7:0] d,
    output logic [2:0] nak);
    logic [7:0] q;
    nak = 3'h0;
    if (useReg)
    begin
      start();
      xfer({sa, 1'b0}, 1'b1, q, nak[2]);
      xfer(ra, 1'b1, q, nak[1]);
    end
    start();
    xfer({sa, 1'b1}, 1'b1, q, nak[0]);
    xfer(8'hff, 1'b0, d, q[0]);
    stop();
  endtask
endmodule // scr_bus_master

// File: verification/scr_config_regs_bench.sv
// Self-checking bench for the switch configuration register bank
`timescale 1ns/1ps
module scr_config_regs_bench;
  localparam logic [6:0] SA = {scr_pkg::SLAVE_ADDR_FIXED, 3'h5};
  localparam int unsigned WinHs = 400;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addrStrap = 3'h5;
  logic strapEnable = 1'b1, strapEqualizer = 1'b1, strapOutTermination = 1'b1, strapOutCurrent = 1'b1;
  logic [1:0] strapChannelSel = 2'h2, strapPreemphasis = 2'h3;
  logic scl, mOe, sdaW, sdaOut, sdaOe, serialCtrlActive, fastPathEnable, sidePathEnable, inputTermSel;
  logic equalizerBoost, outTermEnable, outCurrentLevel;
  logic [1:0] fastPathSwitchMode, sidePathSwitchMode, preemphasisLevel;
  logic [3:0] fastPathSourceSel, sidePathSourceSel;
  logic [7:0] termPulseSel, d;
  logic [2:0] nak;
  int unsigned nMismatch = 0, totalChecks = 0, cycles = 0;
  // Pull-up on the data wire; both parties only pull low
  assign sdaW = (sdaOe ? sdaOut : 1'b1) & !mOe;
  scr_config_regs #(.UpdCyc('{WinHs, 4, 4, 4, 4})) dut (.clk, .rstn, .sclIn(scl), .sdaIn(sdaW), .sdaOut,
    .sdaOe, .slaveAddrStrap2(addrStrap[2]), .slaveAddrStrap1(addrStrap[1]), .slaveAddrStrap0(addrStrap[0]),
    .strapEnable, .strapChannelSel, .strapEqualizer, .strapPreemphasis, .strapOutTermination,
    .strapOutCurrent, .fastPathEnable, .fastPathSwitchMode, .fastPathSourceSel, .sidePathEnable,
    .sidePathSwitchMode, .sidePathSourceSel, .inputTermSel, .termPulseSel, .equalizerBoost,
    .preemphasisLevel, .outTermEnable, .outCurrentLevel, .serialCtrlActive);
  scr_bus_master mst (.clk, .sdaIn(sdaW), .scl, .mOe);
  always #50 clk = ~clk;
  function automatic logic [7:0] hs();
    return {1'b0, fastPathEnable, fastPathSwitchMode, fastPathSourceSel};
  endfunction
  function automatic logic [7:0] ex();
    return {3'h0, equalizerBoost, preemphasisLevel, outTermEnable, outCurrentLevel};
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Ceiling sits well above the roughly 5900 cycles the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      nMismatch++;
      results();
    end
  end
  task automatic t_strap();
    repeat (WinHs + 20) @(negedge clk);
    chk("fastPar", hs(), 8'h42);
    chk("sideSrc", {4'h0, sidePathSourceSel}, 8'h02);
    chk("extras", ex(), 8'h1f);
    strapChannelSel = 2'h1;
    strapEnable = 1'b0;
    strapEqualizer = 1'b0;
    repeat (12) @(negedge clk);
    chk("fastNow", hs(), 8'h01);
    chk("extrasNow", ex(), 8'h0f);
    strapChannelSel = 2'h3;
    repeat (12) @(negedge clk);
    chk("fastHeld", hs(), 8'h01);
    repeat (WinHs) @(negedge clk);
    chk("fastLate", hs(), 8'h03);
    $display("t_strap done");
  endtask
  task automatic t_foreign();
    mst.wr({scr_pkg::SLAVE_ADDR_FIXED, 3'h2}, scr_pkg::ADDR_RX, 8'h00, nak);
    chk("foreignNak", {5'h0, nak}, 8'h07);
    chk("serial", {7'h0, serialCtrlActive}, 8'h00);
    $display("t_foreign done");
  endtask
  task automatic t_takeover();
    logic [7:0] ra [4] = '{scr_pkg::ADDR_HS, scr_pkg::ADDR_AUX, scr_pkg::ADDR_RX, scr_pkg::ADDR_PULSE};
    logic [7:0] rv [4] = '{8'h40, 8'h40, 8'h01, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      mst.rd(SA, ra[i], 1'b1, d, nak);
      chk("rstVal", d, rv[i]);
      chk("rdAck", {5'h0, nak}, 8'h00);
    end
    chk("serial", {7'h0, serialCtrlActive}, 8'h01);
    chk("fastSer", hs(), 8'h40);
    strapEqualizer = 1'b1;
    repeat (12) @(negedge clk);
    chk("frozen", ex(), 8'h0f);
    $display("t_takeover done");
  endtask
  task automatic t_regs();
    logic [7:0] ra [4] = '{8'h05, scr_pkg::ADDR_AUX, scr_pkg::ADDR_RX, scr_pkg::ADDR_PULSE};
    logic [7:0] wd [4] = '{8'h77, 8'h1b, 8'hfe, 8'ha5};
    logic [7:0] rv [4] = '{8'h00, 8'h1b, 8'h00, 8'ha5};
    for (int i = 0; i < 4; i++)
    begin
      mst.wr(SA, ra[i], wd[i], nak);
      chk("wrAck", {5'h0, nak}, 8'h00);
      mst.rd(SA, ra[i], 1'b1, d, nak);
      chk("readBack", d, rv[i]);
    end
    chk("side", {1'b0, sidePathEnable, sidePathSwitchMode, sidePathSourceSel}, 8'h1b);
    chk("term", {7'h0, inputTermSel}, 8'h00);
    chk("pulse", termPulseSel, 8'ha5);
    mst.rd(SA, 8'h00, 1'b0, d, nak);
    chk("retained", d, 8'ha5);
    $display("t_regs done");
  endtask
  task automatic t_window();
    repeat (WinHs) @(negedge clk);
    mst.wr(SA, scr_pkg::ADDR_HS, 8'h25, nak);
    repeat (4) @(negedge clk);
    chk("hsNow", hs(), 8'h25);
    mst.wr(SA, scr_pkg::ADDR_HS, 8'h31, nak);
    chk("hsHeld", hs(), 8'h25);
    // A restarted window would still hold the old value here
    repeat (200) @(negedge clk);
    chk("hsLate", hs(), 8'h21);
    $display("t_window done");
  endtask
  task automatic t_reset2();
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk("serialRst", {7'h0, serialCtrlActive}, 8'h00);
    repeat (12) @(negedge clk);
    chk("fastPar2", hs(), 8'h03);
    $display("t_reset2 done");
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    t_strap();
    t_foreign();
    t_takeover();
    t_regs();
    t_window();
    t_reset2();
    results();
  end
endmodule // scr_config_regs_bench
